/* File: design/pie_pkg.sv */
package pie_pkg;
    localparam int PIE_DATA_W = 8;
    localparam int PIE_ADDR_W = 8;
    localparam int PIE_BANK_W = 4;
    localparam int PIE_SRC_N = 8;

    localparam logic [PIE_ADDR_W-1:0] PIE_FLAG_ADDR = 8'h16;
    localparam logic [PIE_ADDR_W-1:0] PIE_ENABLE_ADDR = 8'h17;
    localparam logic [PIE_ADDR_W-1:0] PIE_CTRL_ADDR = 8'h18;
    localparam logic [PIE_BANK_W-1:0] PIE_REG_BANK = 4'h1;

    localparam logic [PIE_DATA_W-1:0] PIE_ENABLE_RESET = 8'h00;
    localparam logic [PIE_DATA_W-1:0] PIE_FLAG_RESET = 8'h00;

    localparam int PIE_BIT_PORT_CHANGE = 7;
    localparam int PIE_BIT_TIMER3 = 6;
    localparam int PIE_BIT_TIMER2 = 5;
    localparam int PIE_BIT_TIMER1 = 4;
    localparam int PIE_BIT_CAPTURE2 = 3;
    localparam int PIE_BIT_CAPTURE1 = 2;
    localparam int PIE_BIT_TX_EMPTY = 1;
    localparam int PIE_BIT_RX_FULL = 0;

    localparam int PIE_CTRL_GROUP_EN = 0;
    localparam int PIE_CTRL_GLOBAL_DIS = 1;
    localparam logic PIE_GROUP_EN_RESET = 1'b0;
    localparam logic PIE_GLOBAL_DIS_RESET = 1'b1;
endpackage

/* File: design/pie_flag_cell.sv */
`timescale 1ns/100ps
module pie_flag_cell
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic set_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    input wire logic enable_i,
    output logic flag_o,
    output logic req_o
);
    import pie_pkg::*;

    logic flag_q;
    logic flag_d;

    // Hardware set wins over a software clear in the same cycle
    always_comb
    begin
        flag_d = flag_q;
        if (wr_i)
        begin
            flag_d = wdata_i;
        end
        if (set_i)
        begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            flag_q <= PIE_FLAG_RESET[0];
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
    assign req_o = flag_q & enable_i;
endmodule

/* File: design/pie_irq_enable.sv */
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module pie_irq_enable
    import pie_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [pie_pkg::PIE_ADDR_W-1:0] addr_i,
    input wire logic [pie_pkg::PIE_BANK_W-1:0] bank_i,
    input wire logic [pie_pkg::PIE_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic port_change_i,
    input wire logic timer3_evt_i,
    input wire logic timer2_evt_i,
    input wire logic timer1_evt_i,
    input wire logic capture2_pin_evt_i,
    input wire logic capture1_pin_evt_i,
    input wire logic tx_empty_i,
    input wire logic rx_full_i,
    output logic [pie_pkg::PIE_DATA_W-1:0] rdata_o,
    output logic [pie_pkg::PIE_DATA_W-1:0] flags_o,
    output logic periph_req_o,
    output logic periph_irq_o
);
    import pie_pkg::*;

    logic [PIE_DATA_W-1:0] enable_q;
    logic [PIE_DATA_W-1:0] rdata_q;
    logic [PIE_DATA_W-1:0] flags_q;
    logic [PIE_SRC_N-1:0] src_set;
    logic [PIE_SRC_N-1:0] flag_bits;
    logic [PIE_SRC_N-1:0] req_bits;
    logic group_en_q;
    logic global_dis_q;
    logic periph_req_q;
    logic periph_irq_q;
    logic in_bank;
    logic hit_enable;
    logic hit_flag;
    logic hit_ctrl;

    // Positions follow the enable register layout
    always_comb
    begin
        src_set = '0;
        src_set[PIE_BIT_PORT_CHANGE] = port_change_i;
        src_set[PIE_BIT_TIMER3] = timer3_evt_i;
        src_set[PIE_BIT_TIMER2] = timer2_evt_i;
        src_set[PIE_BIT_TIMER1] = timer1_evt_i;
        src_set[PIE_BIT_CAPTURE2] = capture2_pin_evt_i;
        src_set[PIE_BIT_CAPTURE1] = capture1_pin_evt_i;
        src_set[PIE_BIT_TX_EMPTY] = tx_empty_i;
        src_set[PIE_BIT_RX_FULL] = rx_full_i;
    end

    assign in_bank = (bank_i == PIE_REG_BANK);
    assign hit_enable = in_bank && (addr_i == PIE_ENABLE_ADDR);
    assign hit_flag = in_bank && (addr_i == PIE_FLAG_ADDR);
    assign hit_ctrl = in_bank && (addr_i == PIE_CTRL_ADDR);

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            enable_q <= PIE_ENABLE_RESET;
        end
        else if (wr_i && hit_enable)
        begin
            enable_q <= wdata_i;
        end
    end

    // Group enable and global disable live together in one control word
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            group_en_q <= PIE_GROUP_EN_RESET;
            global_dis_q <= PIE_GLOBAL_DIS_RESET;
        end
        else if (wr_i && hit_ctrl)
        begin
            group_en_q <= wdata_i[PIE_CTRL_GROUP_EN];
            global_dis_q <= wdata_i[PIE_CTRL_GLOBAL_DIS];
        end
    end

    // One cell per source; flags set regardless of enable or global disable
    genvar gi;
    generate
        for (gi = 0; gi < PIE_SRC_N; gi++)
        begin : g_cell
            pie_flag_cell u_cell (
                .clock_i(clock_i),
                .reset_i(reset_i),
                .set_i(src_set[gi]),
                .wr_i(wr_i && hit_flag),
                .wdata_i(wdata_i[gi]),
                .enable_i(enable_q[gi]),
                .flag_o(flag_bits[gi]),
                .req_o(req_bits[gi])
            );
        end
    endgenerate

    // Registered so every output comes straight from a flop; costs one cycle of latency
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            periph_req_q <= 1'b0;
            periph_irq_q <= 1'b0;
            flags_q <= PIE_FLAG_RESET;
        end
        else
        begin
            periph_req_q <= |req_bits;
            periph_irq_q <= (|req_bits) && group_en_q && !global_dis_q;
            flags_q <= flag_bits;
        end
    end

    // Unmapped reads answer zero
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            rdata_q <= '0;
        end
        else if (rd_i)
        begin
            if (hit_enable)
            begin
                rdata_q <= enable_q;
            end
            else if (hit_flag)
            begin
                rdata_q <= flag_bits;
            end
            else if (hit_ctrl)
            begin
                rdata_q <= '0;
                rdata_q[PIE_CTRL_GROUP_EN] <= group_en_q;
                rdata_q[PIE_CTRL_GLOBAL_DIS] <= global_dis_q;
            end
            else
            begin
                rdata_q <= '0;
            end
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    assign rdata_o = rdata_q;
    assign flags_o = flags_q;
    assign periph_req_o = periph_req_q;
    assign periph_irq_o = periph_irq_q;

    // Reset sits in the antecedents of the $stable checks below: a one-cycle reset in mid-run would
    // otherwise leave attempts that compare against the state from before it
    enable_reset_a: assert property (
        @(posedge clock_i) reset_i |=> (enable_q == PIE_ENABLE_RESET))
        else $error("enable register not clear after reset");

    enable_hold_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (!reset_i && !(wr_i && hit_enable)) |=> $stable(enable_q))
        else $error("enable register changed without a write");

    bank_guard_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (!reset_i && wr_i && !in_bank) |=> $stable(enable_q))
        else $error("write to another bank reached the enable register");

    flag_bank_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (!reset_i && wr_i && !in_bank && (src_set == 8'h00)) |=> $stable(flag_bits))
        else $error("write to another bank reached the flags");

    ctrl_bank_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (!reset_i && wr_i && !in_bank)
        |=> ($stable(group_en_q) && $stable(global_dis_q)))
        else $error("write to another bank reached the control bits");

    enable_write_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (wr_i && hit_enable) |=> (enable_q == $past(wdata_i)))
        else $error("enable write not stored");

    enable_read_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (rd_i && hit_enable && !wr_i) |=> (rdata_o == $past(enable_q)))
        else $error("enable read data wrong");

    flag_read_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (rd_i && hit_flag && !wr_i) |=> (rdata_o == $past(flag_bits)))
        else $error("flag read data wrong");

    ctrl_read_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (rd_i && hit_ctrl && !wr_i)
        |=> ((rdata_o[PIE_CTRL_GLOBAL_DIS] == $past(global_dis_q))
            && (rdata_o[PIE_CTRL_GROUP_EN] == $past(group_en_q))))
        else $error("control read data wrong");

    unmapped_read_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (rd_i && !hit_enable && !hit_flag && !hit_ctrl) |=> (rdata_o == 8'h00))
        else $error("unmapped read not zero");

    bank_read_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (rd_i && !in_bank) |=> (rdata_o == 8'h00))
        else $error("read from another bank not zero");

    read_idle_a: assert property (
        @(posedge clock_i) !rd_i |=> (rdata_o == 8'h00))
        else $error("read data stood outside its cycle");

    ctrl_write_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (wr_i && hit_ctrl)
        |=> ((group_en_q == $past(wdata_i[PIE_CTRL_GROUP_EN]))
            && (global_dis_q == $past(wdata_i[PIE_CTRL_GLOBAL_DIS]))))
        else $error("control write not stored");

    ctrl_hold_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (!reset_i && !(wr_i && hit_ctrl))
        |=> ($stable(group_en_q) && $stable(global_dis_q)))
        else $error("control bits changed without a write");

    generate
        for (gi = 0; gi < PIE_SRC_N; gi++)
        begin : g_chk
            bit_mask_a: assert property (
                @(posedge clock_i) disable iff (reset_i)
                (!enable_q[gi] && ((req_bits & ~(8'h01 << gi)) == 8'h00))
                |=> !periph_req_o)
                else $error("masked source raised request");

            bit_pass_a: assert property (
                @(posedge clock_i) disable iff (reset_i)
                (!reset_i && flag_bits[gi] && enable_q[gi]) |=> periph_req_o)
                else $error("enabled source did not raise request");

            flag_set_a: assert property (
                @(posedge clock_i) disable iff (reset_i)
                (!reset_i && src_set[gi]) |=> flag_bits[gi])
                else $error("flag not set by source");

            flag_hold_a: assert property (
                @(posedge clock_i) disable iff (reset_i)
                (!reset_i && flag_bits[gi] && !(wr_i && hit_flag)) |=> flag_bits[gi])
                else $error("flag dropped without a write");

            flag_clear_a: assert property (
                @(posedge clock_i) disable iff (reset_i)
                (!reset_i && wr_i && hit_flag && !wdata_i[gi] && !src_set[gi])
                |=> !flag_bits[gi])
                else $error("flag not cleared by software");

            flag_write_a: assert property (
                @(posedge clock_i) disable iff (reset_i)
                (!reset_i && wr_i && hit_flag && wdata_i[gi]) |=> flag_bits[gi])
                else $error("flag not set by software");

            set_wins_a: assert property (
                @(posedge clock_i) disable iff (reset_i)
                (!reset_i && src_set[gi] && wr_i && hit_flag && !wdata_i[gi])
                |=> flag_bits[gi])
                else $error("software clear beat a source set");
        end
    endgenerate

    flags_copy_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        !reset_i |=> (flags_o == $past(flag_bits)))
        else $error("flag copy out of step");

    group_block_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        !group_en_q |=> !periph_irq_o)
        else $error("interrupt passed with group disabled");

    global_block_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        global_dis_q |=> !periph_irq_o)
        else $error("interrupt passed with global disable set");

    irq_pass_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (!reset_i && (|req_bits) && group_en_q && !global_dis_q) |=> periph_irq_o)
        else $error("unmasked request did not raise interrupt");

    irq_low_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (req_bits == 8'h00) |=> (!periph_req_o && !periph_irq_o))
        else $error("request without a pending enabled flag");

    irq_req_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        periph_irq_o |-> periph_req_o)
        else $error("interrupt without the combined request");

    req_flags_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        !reset_i |=> (periph_req_o == (|(flags_o & $past(enable_q)))))
        else $error("request disagrees with flag copy and enables");

    global_reset_a: assert property (
        @(posedge clock_i) reset_i |=> (global_dis_q && !periph_irq_o))
        else $error("global disable not set by reset");

    outputs_reset_a: assert property (
        @(posedge clock_i)
        reset_i |=> (!periph_req_o && (flags_o == 8'h00) && (rdata_o == 8'h00)))
        else $error("outputs not clear after reset");

    combine_req_a: assert property (
        @(posedge clock_i) disable iff (reset_i)
        !reset_i |=> (periph_req_o == (|($past(flag_bits) & $past(enable_q)))))
        else $error("combined request mismatch");
endmodule

/* File: tb/pie_src_model.sv */
`timescale 1ns/100ps
module pie_src_model
    import pie_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [pie_pkg::PIE_SRC_N-1:0] trig_i,
    output logic [pie_pkg::PIE_SRC_N-1:0] evt_o
);
    // Registered so events move just after an edge, as a real timer or serial unit would
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            evt_o <= '0;
        end
        else
        begin
            evt_o <= trig_i;
        end
    end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
    import pie_pkg::*;
    logic clock_i = 0;
    logic reset_i = 1;
    logic [7:0] addr_i = 0;
    logic [7:0] wdata_i = 0;
    logic [3:0] bank_i = 0;
    logic wr_i = 0;
    logic rd_i = 0;
    logic [7:0] trig = 0;
    logic [7:0] evt;
    logic [7:0] rdata_o;
    logic [7:0] flags_o;
    logic periph_req_o;
    logic periph_irq_o;
    logic [7:0] v;
    logic [7:0] e;
    logic [7:0] f;
    int err_count = 0;
    int total_checks = 0;
    pie_src_model src (.clock_i(clock_i), .reset_i(reset_i), .trig_i(trig), .evt_o(evt));
    pie_irq_enable uut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
        .bank_i(bank_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .port_change_i(evt[7]), .timer3_evt_i(evt[6]), .timer2_evt_i(evt[5]),
        .timer1_evt_i(evt[4]), .capture2_pin_evt_i(evt[3]), .capture1_pin_evt_i(evt[2]),
        .tx_empty_i(evt[1]), .rx_full_i(evt[0]), .rdata_o(rdata_o), .flags_o(flags_o),
        .periph_req_o(periph_req_o), .periph_irq_o(periph_irq_o));
    initial forever #10 clock_i = ~clock_i;
    function automatic logic [7:0] exp_req(input logic [7:0] fl, input logic [7:0] en);
        return {7'h00, |(fl & en)};
    endfunction
    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        total_checks++;
        if (g !== x)
        begin
            $display("wrong value %s expected %h seen %h", n, x, g);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] b = 4'h1);
        @(posedge clock_i);
        wr_i <= 1;
        addr_i <= a;
        wdata_i <= d;
        bank_i <= b;
        @(posedge clock_i);
        wr_i <= 0;
        bank_i <= PIE_REG_BANK;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        rd_i <= 1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 0;
        #1 d = rdata_o;
    endtask
    // Pulse sources, then let flag and the registered request settle
    task automatic fire(input logic [7:0] m);
        @(posedge clock_i);
        trig <= m;
        @(posedge clock_i);
        trig <= 0;
        repeat (4) @(posedge clock_i);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        v = $urandom(63);
        repeat (10) @(posedge clock_i);
        reset_i <= 0;
        bank_i <= PIE_REG_BANK;
        rd(PIE_ENABLE_ADDR, v);
        chk("enable reset", PIE_ENABLE_RESET, v);
        rd(PIE_CTRL_ADDR, v);
        chk("ctrl reset", 8'h02, v);
        $display("test reset values done");
        for (int i = 0; i < 6; i++)
        begin
            e = (i == 0) ? 8'hFF : 8'($urandom);
            wr(PIE_ENABLE_ADDR, e);
            rd(PIE_ENABLE_ADDR, v);
            chk("enable rw", e, v);
        end
        wr(PIE_ENABLE_ADDR, ~e, 4'h2);
        rd(PIE_ENABLE_ADDR, v);
        chk("other bank", e, v);
        rd(8'h40, v);
        chk("unmapped", 8'h00, v);
        $display("test register access done");
        wr(PIE_CTRL_ADDR, 8'h01);
        rd(PIE_CTRL_ADDR, v);
        chk("ctrl rw", 8'h01, v);
        // Masked pass keeps all other enables set, so a wrong bit lane shows up
        for (int i = 0; i < 8; i++)
        begin
            for (int en = 0; en < 2; en++)
            begin
                wr(PIE_FLAG_ADDR, 8'h00);
                wr(PIE_ENABLE_ADDR, en ? (8'h01 << i) : ~(8'h01 << i));
                fire(8'h01 << i);
                chk("flags", 8'h01 << i, flags_o);
                chk("req", 8'(en), {7'h00, periph_req_o});
                chk("irq", 8'(en), {7'h00, periph_irq_o});
            end
        end
        $display("test per source done");
        wr(PIE_CTRL_ADDR, 8'h00);
        fire(8'h00);
        chk("group off", 8'h00, {7'h00, periph_irq_o});
        wr(PIE_CTRL_ADDR, 8'h03);
        fire(8'h00);
        chk("global off", 8'h00, {7'h00, periph_irq_o});
        chk("req kept", 8'h01, {7'h00, periph_req_o});
        $display("test gating done");
        // Source pulse and software clear meet at one edge; the set must survive
        wr(PIE_FLAG_ADDR, 8'hFF);
        @(posedge clock_i);
        trig <= 8'h20;
        @(posedge clock_i);
        trig <= 0;
        wr_i <= 1;
        addr_i <= PIE_FLAG_ADDR;
        wdata_i <= 8'h00;
        @(posedge clock_i);
        wr_i <= 0;
        fire(8'h00);
        chk("set wins", 8'h20, flags_o);
        $display("test set over clear done");
        for (int i = 0; i < 24; i++)
        begin
            f = (i == 0) ? 8'h00 : 8'($urandom);
            e = (i == 1) ? 8'h00 : 8'($urandom);
            wr(PIE_FLAG_ADDR, f);
            wr(PIE_ENABLE_ADDR, e);
            fire(8'h00);
            chk("flags rand", f, flags_o);
            chk("req rand", exp_req(f, e), {7'h00, periph_req_o});
            chk("irq blocked", 8'h00, {7'h00, periph_irq_o});
            rd(PIE_FLAG_ADDR, v);
            chk("flag read", f, v);
        end
        $display("test random combine done");
        @(posedge clock_i);
        reset_i <= 1;
        @(posedge clock_i);
        reset_i <= 0;
        rd(PIE_ENABLE_ADDR, v);
        chk("enable rerst", 8'h00, v);
        rd(PIE_CTRL_ADDR, v);
        chk("ctrl rerst", 8'h02, v);
        $display("test mid reset done");
        give_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        give_verdict;
    end
endmodule
